// >>> hw/debug_trigger_state_sequencer.v
// Purpose: next-state selection of a debug trigger state sequencer
// Assumes: match inputs synchronous to clock, one pulse or level per cycle
// Notes: registers reached over a plain strobed port, read data one cycle later
`timescale 1ns/1ps
`include "sequencer_defs.vh"

module debug_trigger_state_sequencer #(
  parameter CHANNELS = 4,
  parameter ADDR_WIDTH = 8,
  parameter DATA_WIDTH = 8
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // register port
  input wire [ADDR_WIDTH-1:0] address,
  input wire [DATA_WIDTH-1:0] write_data,
  input wire write_strobe,
  input wire read_strobe,
  output reg [DATA_WIDTH-1:0] read_data,
  // comparator match channels
  input wire [CHANNELS-1:0] match,
  // sequencer state
  output reg [1:0] sequencer_state,
  output reg armed,
  output reg final_reached,
  output reg state_changed
);

  ////////////////////////////////////////////////////////////////////////////////
  // software registers
  reg [1:0] comparator_view_select;
  reg [3:0] state1_select;
  reg [3:0] state2_next_state_select;
  reg [CHANNELS-1:0] comparator_enable;
  reg [CHANNELS-1:0] match_seen;

  // decode
  wire wr_control;
  wire wr_status;
  wire wr_state1;
  wire wr_state2;
  wire view_is_state2;
  wire [CHANNELS-1:0] wr_cmp;
  wire [CHANNELS-1:0] match_gated;

  // next values
  reg [1:0] next_state;
  reg [2:0] next_target;
  reg final_hit;

  // per channel targets, three bits each
  wire [3*CHANNELS-1:0] chan_tgt;
  wire [CHANNELS-1:0] chan_live;
  wire [CHANNELS-1:0] chan_final;

  // address decode
  wire sel_control;
  wire sel_status;
  wire sel_state1;
  wire sel_state2;
  wire sel_cmp;
  wire disarm;
  reg [DATA_WIDTH-1:0] next_read_data;
  integer ch;

  assign sel_control = (address == `OFS_CONTROL);
  assign sel_status = (address == `OFS_STATUS);
  assign sel_state1 = (address == `OFS_STATE1_SELECT);
  assign sel_state2 = (address == `OFS_STATE2_SELECT);
  assign sel_cmp = (address >= `OFS_CMP_CONTROL_BASE) && (address <= `OFS_CMP_CONTROL_LAST);

  assign view_is_state2 = (comparator_view_select == `VIEW_STATE2);
  assign wr_control = write_strobe && sel_control;
  assign wr_status = write_strobe && sel_status;
  assign wr_state1 = write_strobe && sel_state1 && !armed;
  // writes outside view 01 or while armed are dropped
  assign wr_state2 = write_strobe && sel_state2 && view_is_state2 &&
    !armed;
  // disarming restarts the sequence and beats a same-cycle match
  assign disarm = wr_control && !write_data[`CTRL_ARM_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // per channel comparator control and match gating
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : chan
      localparam [ADDR_WIDTH-1:0] CMP_ADDR = `OFS_CMP_CONTROL_BASE + gi;
      assign wr_cmp[gi] = write_strobe && (address == CMP_ADDR);
      // disabled comparators never reach the sequencer
      assign match_gated[gi] = match[gi] && comparator_enable[gi];

      always @(posedge clock) begin
        if (!resetn) begin
          comparator_enable[gi] <= 1'b0;
          match_seen[gi] <= 1'b0;
        end else begin
          if (wr_cmp[gi]) begin
            comparator_enable[gi] <= write_data[`CMP_ENABLE_BIT];
          end
          // a new match wins over a write-one clear in the same cycle
          if (match_gated[gi] && armed) begin
            match_seen[gi] <= 1'b1;
          end else if (wr_status && write_data[`STAT_SEEN_LO + gi]) begin
            match_seen[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // state1 target per channel
  function [2:0] state1_target;
    input [3:0] code;
    input [1:0] chan;
    begin
      state1_target = `TGT_NONE;
      case (code)
        `S1_M2_TO_S2: begin
          if (chan == 2'd2) state1_target = `TGT_S2;
        end
        `S1_M2_TO_S3: begin
          if (chan == 2'd2) state1_target = `TGT_S3;
        end
        `S1_M2_TO_FINAL: begin
          if (chan == 2'd2) state1_target = `TGT_FINAL;
        end
        `S1_M0S2_M1S3: begin
          if (chan == 2'd0) state1_target = `TGT_S2;
          else if (chan == 2'd1) state1_target = `TGT_S3;
        end
        `S1_M1S3_M0F: begin
          if (chan == 2'd1) state1_target = `TGT_S3;
          else if (chan == 2'd0) state1_target = `TGT_FINAL;
        end
        `S1_M0S2_M2S3: begin
          if (chan == 2'd0) state1_target = `TGT_S2;
          else if (chan == 2'd2) state1_target = `TGT_S3;
        end
        `S1_M2S3_M0F: begin
          if (chan == 2'd2) state1_target = `TGT_S3;
          else if (chan == 2'd0) state1_target = `TGT_FINAL;
        end
        `S1_M1S2_M3S3: begin
          if (chan == 2'd1) state1_target = `TGT_S2;
          else if (chan == 2'd3) state1_target = `TGT_S3;
        end
        `S1_M3S3_M1F: begin
          if (chan == 2'd3) state1_target = `TGT_S3;
          else if (chan == 2'd1) state1_target = `TGT_FINAL;
        end
        `S1_M012_TO_S2: begin
          if (chan != 2'd3) state1_target = `TGT_S2;
        end
        // reserved and unlisted codes never move the sequencer
        default: begin
          state1_target = `TGT_NONE;
        end
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state2 target per channel
  function [2:0] state2_target;
    input [3:0] code;
    begin
      case (code)
        `S2_ANY_TO_S1: state2_target = `TGT_S1;
        default: state2_target = `TGT_NONE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // next state selection
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : tgt
      localparam [1:0] CHAN_ID = gi;
      reg [2:0] tgt_value;
      always @* begin
        tgt_value = `TGT_NONE;
        case (sequencer_state)
          `SEQ_STATE1: begin
            tgt_value = state1_target(state1_select, CHAN_ID);
          end
          `SEQ_STATE2: begin
            // the state2 code is the low nibble of its register
            tgt_value = state2_target(state2_next_state_select);
          end
          default: begin
            tgt_value = `TGT_NONE;
          end
        endcase
      end
      assign chan_tgt[3*gi +: 3] = tgt_value;
      assign chan_live[gi] = match_gated[gi] && tgt_value[2];
      assign chan_final[gi] = chan_live[gi] && (tgt_value == `TGT_FINAL);
    end
  endgenerate

  always @* begin
    next_target = `TGT_NONE;
    final_hit = |chan_final;
    // scan high to low so the lowest live channel is kept
    for (ch = CHANNELS - 1; ch >= 0; ch = ch - 1) begin
      if (chan_live[ch]) begin
        next_target = chan_tgt[3*ch +: 3];
      end
    end
    if (final_hit) begin
      next_target = `TGT_FINAL;
    end
    next_state = sequencer_state;
    if (armed && next_target[2]) begin
      next_state = next_target[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control and selection registers
  always @(posedge clock) begin
    if (!resetn) begin
      armed <= 1'b0;
      comparator_view_select <= `VIEW_RESET;
      state1_select <= `CODE_RESET;
      state2_next_state_select <= `CODE_RESET;
    end else begin
      if (wr_control) begin
        comparator_view_select <= write_data[`CTRL_VIEW_HI:`CTRL_VIEW_LO];
        armed <= write_data[`CTRL_ARM_BIT];
      end
      if (wr_state1) begin
        state1_select <= write_data[3:0];
      end
      if (wr_state2) begin
        state2_next_state_select <= write_data[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer state
  always @(posedge clock) begin
    if (!resetn) begin
      sequencer_state <= `SEQ_STATE1;
      final_reached <= 1'b0;
      state_changed <= 1'b0;
    end else begin
      state_changed <= 1'b0;
      if (disarm) begin
        sequencer_state <= `SEQ_STATE1;
        final_reached <= 1'b0;
      end else if (next_state != sequencer_state) begin
        sequencer_state <= next_state;
        state_changed <= 1'b1;
        if (next_state == `SEQ_FINAL) begin
          final_reached <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path
  always @* begin
    next_read_data = `BYTE_ZERO;
    if (sel_control) begin
      next_read_data[`CTRL_VIEW_HI:`CTRL_VIEW_LO] = comparator_view_select;
      next_read_data[`CTRL_ARM_BIT] = armed;
    end else if (sel_status) begin
      next_read_data[`STAT_STATE_HI:`STAT_STATE_LO] = sequencer_state;
      next_read_data[`STAT_ARMED_BIT] = armed;
      next_read_data[`STAT_FINAL_BIT] = final_reached;
      next_read_data[`STAT_SEEN_HI:`STAT_SEEN_LO] = match_seen;
    end else if (sel_state1) begin
      next_read_data[3:0] = state1_select;
    end else if (sel_state2) begin
      if (view_is_state2) begin
        next_read_data[3:0] = state2_next_state_select;
      end
    end else if (sel_cmp) begin
      next_read_data[`CMP_ENABLE_BIT] =
        comparator_enable[address[1:0]];
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      read_data <= `BYTE_ZERO;
    end else if (read_strobe) begin
      read_data <= next_read_data;
    end else begin
      read_data <= `BYTE_ZERO;
    end
  end

endmodule

// >>> inc/sequencer_defs.vh
// Purpose: constants for the debug trigger state sequencer
// Assumes: 8-bit register port, byte-wide registers
// Notes: offsets are byte addresses on the register port
`ifndef SEQUENCER_DEFS_VH
`define SEQUENCER_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// register offsets
`define OFS_CONTROL 8'h20
`define OFS_STATUS 8'h21
`define OFS_STATE1_SELECT 8'h22
`define OFS_STATE2_SELECT 8'h27
`define OFS_CMP_CONTROL_BASE 8'h28
`define OFS_CMP_CONTROL_LAST 8'h2B

////////////////////////////////////////////////////////////////////////////////
// field positions
`define CTRL_VIEW_LO 0
`define CTRL_VIEW_HI 1
`define CTRL_ARM_BIT 7
`define CMP_ENABLE_BIT 0
`define STAT_STATE_LO 0
`define STAT_STATE_HI 1
`define STAT_ARMED_BIT 2
`define STAT_FINAL_BIT 3
`define STAT_SEEN_LO 4
`define STAT_SEEN_HI 7

////////////////////////////////////////////////////////////////////////////////
// field values and reset values
`define VIEW_STATE2 2'h1
`define VIEW_RESET 2'h0
`define CODE_RESET 4'h0
`define BYTE_ZERO 8'h00

////////////////////////////////////////////////////////////////////////////////
// sequencer states
`define SEQ_STATE1 2'h0
`define SEQ_STATE2 2'h1
`define SEQ_STATE3 2'h2
`define SEQ_FINAL 2'h3

////////////////////////////////////////////////////////////////////////////////
// state1 selection codes
`define S1_M2_TO_S2 4'h3
`define S1_M2_TO_S3 4'h4
`define S1_M2_TO_FINAL 4'h5
`define S1_M0S2_M1S3 4'h6
`define S1_M1S3_M0F 4'h7
`define S1_M0S2_M2S3 4'h8
`define S1_M2S3_M0F 4'h9
`define S1_M1S2_M3S3 4'hA
`define S1_M3S3_M1F 4'hB
`define S1_M012_TO_S2 4'hC

// state2 selection codes
`define S2_ANY_TO_S1 4'h0

// target encoding: valid flag above the state
`define TGT_NONE 3'h0
`define TGT_S1 3'h4
`define TGT_S2 3'h5
`define TGT_S3 3'h6
`define TGT_FINAL 3'h7

`endif

// >>> tb/debug_trigger_state_sequencer_assertions.sv
// Purpose: port-level checks for the debug trigger state sequencer
// Assumes: one clock, synchronous active-low reset
// Notes: attached to the design top by bind
`timescale 1ns/1ps
`include "sequencer_defs.vh"
module debug_trigger_state_sequencer_assertions #(
  parameter CHANNELS = 4,
  parameter ADDR_WIDTH = 8,
  parameter DATA_WIDTH = 8
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // register port
  input wire [ADDR_WIDTH-1:0] address,
  input wire [DATA_WIDTH-1:0] write_data,
  input wire write_strobe,
  input wire read_strobe,
  input wire [DATA_WIDTH-1:0] read_data,
  // match and state
  input wire [CHANNELS-1:0] match,
  input wire [1:0] sequencer_state,
  input wire armed,
  input wire final_reached,
  input wire state_changed
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence ctrl_write;
    write_strobe && address == `OFS_CONTROL;
  endsequence
  sequence quiet_cycle;
    !write_strobe && match == 0;
  endsequence
  arm_follows_a: assert property (ctrl_write ##0 write_data[7] |=> armed)
    else $error("armed did not follow control write");
  disarm_return_a: assert property (ctrl_write ##0 !write_data[7] |=>
    !armed && sequencer_state == `SEQ_STATE1 && !final_reached)
    else $error("disarm did not return to state1");
  read_idle_a: assert property (!read_strobe |=> read_data == 0)
    else $error("read data outside read cycle");
  quiet_hold_a: assert property (quiet_cycle |=> $stable(sequencer_state) && !state_changed)
    else $error("state moved without match");
  unarmed_hold_a: assert property (!armed && !write_strobe |=> $stable(sequencer_state))
    else $error("state moved while unarmed");
  change_cause_a: assert property (state_changed |->
    $changed(sequencer_state) && $past(armed) && $past(match) != 0)
    else $error("change pulse without cause");
  final_entry_a: assert property ($rose(final_reached) |->
    sequencer_state == `SEQ_FINAL && state_changed)
    else $error("final flag without final state");
  upper_hold_a: assert property (sequencer_state[1] && !write_strobe |=>
    $stable(sequencer_state))
    else $error("left state3 or final");
  state2_exit_a: assert property (sequencer_state == `SEQ_STATE2 && !write_strobe |=>
    sequencer_state inside {`SEQ_STATE1, `SEQ_STATE2})
    else $error("bad exit from state2");
endmodule
bind debug_trigger_state_sequencer debug_trigger_state_sequencer_assertions #(
  .CHANNELS(CHANNELS), .ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)
) i_checker (.clock(clock), .resetn(resetn), .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
  .match(match), .sequencer_state(sequencer_state), .armed(armed),
  .final_reached(final_reached), .state_changed(state_changed));

// >>> tb/debug_trigger_state_sequencer_bench.sv
// Purpose: directed test of the debug trigger state sequencer
// Assumes: 100 MHz clock, register port with one-cycle read latency
// Notes: table rows are {state1 code, match, expected state}
`timescale 1ns/1ps
`include "sequencer_defs.vh"
module debug_trigger_state_sequencer_bench;
  reg clock, resetn, write_strobe, read_strobe;
  reg [7:0] address, write_data;
  reg [3:0] match;
  wire [7:0] read_data;
  wire [1:0] sequencer_state;
  wire armed, final_reached, state_changed;
  integer error_cnt = 0, total_checks = 0, cycles = 0, i;
  logic [9:0] tbl [0:27] = '{10'h0D1, 10'h0EC, 10'h112, 10'h153, 10'h185, 10'h18A, 10'h1B0,
    10'h1CA, 10'h1CF, 10'h205, 10'h212, 10'h215, 10'h228, 10'h252, 10'h257, 10'h289,
    10'h2A2, 10'h2A9, 10'h2E2, 10'h2EB, 10'h2D4, 10'h305, 10'h309, 10'h311, 10'h320,
    10'h37C, 10'h3BC, 10'h3FC};
  debug_trigger_state_sequencer i_dut (.clock(clock), .resetn(resetn), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .match(match), .sequencer_state(sequencer_state), .armed(armed),
    .final_reached(final_reached), .state_changed(state_changed));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    write_strobe <= 1'b1;
    address <= a;
    write_data <= d;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    read_strobe <= 1'b1;
    address <= a;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 check("read_data", read_data, exp);
  endtask
  task hit(input logic [3:0] m, input logic [1:0] st, input logic chg);
    @(posedge clock);
    match <= m;
    @(posedge clock);
    match <= 4'h0;
    #1 check("sequencer_state", {6'h00, sequencer_state}, {6'h00, st});
    check("state_changed", {7'h00, state_changed}, {7'h00, chg});
  endtask
  task setup(input logic [3:0] code);
    wr(`OFS_CONTROL, 8'h00);
    wr(`OFS_STATE1_SELECT, {4'h0, code});
    wr(`OFS_CONTROL, 8'h80);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    address = 8'h00;
    write_data = 8'h00;
    match = 4'h0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    rd(`OFS_CONTROL, 8'h00);
    rd(`OFS_STATE1_SELECT, 8'h00);
    rd(8'h30, 8'h00);
    $display("test reset values done");
    for (i = 0; i < 4; i = i + 1) wr(8'(`OFS_CMP_CONTROL_BASE + i), 8'h01);
    for (i = 0; i < 28; i = i + 1) begin
      setup(tbl[i][9:6]);
      hit(tbl[i][5:2], tbl[i][1:0], tbl[i][1:0] != `SEQ_STATE1);
    end
    $display("test state1 codes done");
    wr(8'h2A, 8'h00);
    setup(4'h3);
    hit(4'h4, `SEQ_STATE1, 1'b0);
    wr(8'h2A, 8'h01);
    $display("test comparator enable done");
    wr(`OFS_CONTROL, 8'h01);
    wr(`OFS_STATE2_SELECT, 8'hF5);
    rd(`OFS_STATE2_SELECT, 8'h05);
    wr(`OFS_CONTROL, 8'h00);
    rd(`OFS_STATE2_SELECT, 8'h00);
    wr(`OFS_STATE2_SELECT, 8'h0A);
    wr(`OFS_CONTROL, 8'h01);
    rd(`OFS_STATE2_SELECT, 8'h05);
    wr(`OFS_CONTROL, 8'h81);
    wr(`OFS_STATE2_SELECT, 8'h0A);
    rd(`OFS_STATE2_SELECT, 8'h05);
    wr(`OFS_CONTROL, 8'h01);
    wr(`OFS_STATE2_SELECT, 8'hF0);
    rd(`OFS_STATE2_SELECT, 8'h00);
    wr(`OFS_STATE1_SELECT, 8'h03);
    wr(`OFS_CONTROL, 8'h81);
    hit(4'h4, `SEQ_STATE2, 1'b1);
    hit(4'h8, `SEQ_STATE1, 1'b1);
    $display("test state2 register done");
    setup(4'h5);
    hit(4'h4, `SEQ_FINAL, 1'b1);
    check("final_reached", {7'h00, final_reached}, 8'h01);
    rd(`OFS_STATUS, 8'hFF);
    wr(`OFS_STATUS, 8'hF0);
    rd(`OFS_STATUS, 8'h0F);
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    #1 check("flags", {4'h0, armed, final_reached, sequencer_state}, 8'h00);
    $display("test mid-run reset done");
    close_out;
  end
endmodule
